// *** hw/ios_defs.svh ***
// constants of the internal oscillator select block: offsets, fields, resets, timing
// assumes it is included by bare name wherever a value below is used
`ifndef IOS_DEFS_SVH
`define IOS_DEFS_SVH

// ------------
// register map (word index on the plain register port)
// ------------
`define IOS_ADDR_W              4
`define IOS_ADDR_OSC_CONTROL    4'h0
`define IOS_ADDR_OSC_TRIM       4'h1

// ------------
// control register fields
// ------------
`define IOS_CTL_SCS_BIT         0
`define IOS_CTL_SLOW_STB_BIT    1
`define IOS_CTL_FAST_STB_BIT    2
`define IOS_CTL_EXT_RUN_BIT     3
`define IOS_CTL_SEL_LSB         4
`define IOS_CTL_SEL_MSB         6
`define IOS_SEL_RESET           3'h6
`define IOS_SEL_SLOW            3'h0
`define IOS_SEL_FAST_FULL       3'h7
`define IOS_TRIM_W              5
`define IOS_TRIM_RESET          5'h00

// ------------
// timing
// ------------
`define IOS_CLK_PERIOD_NS       50
`define IOS_TRIM_STEP_NS        1000
`define IOS_TRIM_STEP_CYC       ((`IOS_TRIM_STEP_NS + `IOS_CLK_PERIOD_NS - 1) / `IOS_CLK_PERIOD_NS)
`define IOS_DIV_W               6

`endif

// *** hw/ios_pkg.sv ***
// types of the internal oscillator select block
// assumes the constants header is compiled alongside
package ios_pkg;

    // switch sequencer states
    typedef enum logic [1:0] {
        IOS_SW_IDLE      = 2'b00,
        IOS_SW_START     = 2'b01,
        IOS_SW_WAIT_FALL = 2'b10,
        IOS_SW_HOLD_LOW  = 2'b11
    } ios_sw_state_t;

    // oscillator mode configuration field
    typedef enum logic [2:0] {
        IOS_MODE_LP                 = 3'b000,
        IOS_MODE_XT                 = 3'b001,
        IOS_MODE_HS                 = 3'b010,
        IOS_MODE_EC                 = 3'b011,
        IOS_MODE_INTERNAL_WITH_IO   = 3'b100,
        IOS_MODE_INTERNAL_WITH_CLKO = 3'b101,
        IOS_MODE_RC_WITH_IO         = 3'b110,
        IOS_MODE_RC                 = 3'b111
    } ios_osc_mode_t;

endpackage : ios_pkg

// *** hw/ios_sync2.sv ***
// two flip-flop synchroniser for levels entering the core clock domain
// assumes inputs are asynchronous and change slower than the core clock
`timescale 1ns/10ps
`default_nettype none

module ios_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : ios_sync2

`default_nettype wire

// *** hw/ios_osc_select.sv ***
// internal oscillator select: pin modes, oscillator enables, postscaler, trim and
// glitch-free clock switch
// assumes oscillator clocks, ready flags and pins arrive asynchronously; the
// register port is on core_clk
//
// Contract
// - rc mode drives divide-by-four clock out
// - rc with io frees second pin
// - internal divided_clock_out mode: first pin io, divided out
// - internal io mode: both pins io
// - internal modes select internal clock
// - fast enable: nonzero select and select/two-speed
// - fast stable status bit
// - five-bit signed trim, reset zero
// - trim codes ordered min to max
// - trim moves gradually, no done status
// - trim never touches slow oscillator
// - slow oscillator is timer timebase
// - slow enable conditions incl. timers
// - slow stable status bit
// - select picks one of eight frequencies
// - select encoding 111 down to 000
// - select resets to 110
// - start target, wait fall, hold low
// - wait new rise, connect, update status
// - no start delay within postscaler range
// - system clock select chooses source
// - select bit zero follows config, resets clear
`timescale 1ns/10ps
`default_nettype none
`include "ios_defs.svh"

module ios_osc_select #(
    parameter int TRIM_STEP_CYC = `IOS_TRIM_STEP_CYC
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // register port
    input  wire logic [`IOS_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // configuration word
    input  wire logic [2:0]             osc_mode_config,
    input  wire logic                   two_speed_enable,
    input  wire logic                   power_up_delay_timer_en,
    input  wire logic                   watchdog_counter_en,
    input  wire logic                   clock_fail_monitor_en,
    // analog oscillator cells
    input  wire logic                   fast_internal_osc,
    input  wire logic                   slow_internal_osc,
    input  wire logic                   fast_osc_ready,
    input  wire logic                   slow_osc_ready,
    output logic                        fast_osc_enable,
    output logic                        slow_osc_enable,
    output logic      [`IOS_TRIM_W-1:0] trim_value,
    // clocks to the core and timers
    output logic                        sys_clk_out,
    output logic                        slow_timebase_tick,
    // first oscillator pin
    input  wire logic                   osc_pin_in_i,
    output logic                        osc_pin_in_o,
    output logic                        osc_pin_in_oe,
    // second oscillator pin
    input  wire logic                   osc_pin_out_i,
    output logic                        osc_pin_out_o,
    output logic                        osc_pin_out_oe,
    // general purpose io use of the pins
    input  wire logic                   gpio_a_out,
    input  wire logic                   gpio_a_oe,
    input  wire logic                   gpio_b_out,
    input  wire logic                   gpio_b_oe,
    output logic                        gpio_a_in,
    output logic                        gpio_b_in
);

    // ------------
    // input synchronisers
    // ------------
    logic [5:0] async_bus;
    logic [5:0] sync_bus;
    logic       fast_lvl;
    logic       slow_lvl;
    logic       fast_rdy;
    logic       slow_rdy;
    logic       pin_a_lvl;
    logic       pin_b_lvl;

    assign async_bus = {osc_pin_out_i, osc_pin_in_i, slow_osc_ready, fast_osc_ready,
                        slow_internal_osc, fast_internal_osc};

    ios_sync2 #(
        .WIDTH    (6)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (async_bus),
        .sync_out (sync_bus)
    );

    // synchronised ready levels only, never the raw analog flags
    assign fast_lvl  = sync_bus[0];
    assign slow_lvl  = sync_bus[1];
    assign fast_rdy  = sync_bus[2];
    assign slow_rdy  = sync_bus[3];
    assign pin_a_lvl = sync_bus[4];
    assign pin_b_lvl = sync_bus[5];
    assign gpio_a_in = pin_a_lvl;
    assign gpio_b_in = pin_b_lvl;

    // ------------
    // control registers
    // ------------
    logic [2:0]             freq_sel;
    logic                   sys_clk_sel;
    logic [`IOS_TRIM_W-1:0] trim_target;
    logic                   fast_stable;
    logic                   slow_stable;
    logic                   wr_ctl;
    logic                   wr_trim;

    assign wr_ctl  = reg_wr && (reg_addr == `IOS_ADDR_OSC_CONTROL);
    assign wr_trim = reg_wr && (reg_addr == `IOS_ADDR_OSC_TRIM);

    // frequency select and system clock select; status bits are read only
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            freq_sel    <= `IOS_SEL_RESET;
            sys_clk_sel <= 1'b0;
        end else if (wr_ctl) begin
            freq_sel    <= reg_wdata[`IOS_CTL_SEL_MSB:`IOS_CTL_SEL_LSB];
            sys_clk_sel <= reg_wdata[`IOS_CTL_SCS_BIT];
        end
    end

    // trim target as written; upper three bits are not stored
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trim_target <= `IOS_TRIM_RESET;
        end else if (wr_trim) begin
            trim_target <= reg_wdata[`IOS_TRIM_W-1:0];
        end
    end

    // ------------
    // source codes: {external, frequency select}
    // ------------
    localparam logic [3:0] SRC_EXT = 4'h8;

    logic                   internal_mode;
    logic [3:0]             des_src;
    logic [3:0]             cur_src;
    logic [3:0]             tgt_src;
    ios_pkg::ios_sw_state_t sw_state;

    assign internal_mode = (osc_mode_config == ios_pkg::IOS_MODE_INTERNAL_WITH_IO) ||
                           (osc_mode_config == ios_pkg::IOS_MODE_INTERNAL_WITH_CLKO);

    // internal modes run from the internal path even with select bit clear
    assign des_src = (sys_clk_sel || internal_mode) ? {1'b0, freq_sel} : SRC_EXT;

    // ------------
    // postscaler on the fast oscillator
    // ------------
    logic                  fast_lvl_q;
    logic                  slow_lvl_q;
    logic [`IOS_DIV_W-1:0] post_div;

    // edge history of the synchronised oscillator levels
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fast_lvl_q <= 1'b0;
            slow_lvl_q <= 1'b0;
        end else begin
            fast_lvl_q <= fast_lvl;
            slow_lvl_q <= slow_lvl;
        end
    end

    // ripple-free binary postscaler: bit k is the fast clock divided by 2^(k+1)
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            post_div <= '0;
        end else if (fast_lvl && !fast_lvl_q) begin
            post_div <= post_div + 1'b1;
        end
    end

    // the timers see synchronised, undivided slow edges; trim never reaches this path
    assign slow_timebase_tick = slow_lvl && !slow_lvl_q;

    // level of a source code: 111 full rate, 110..001 postscaled, 000 slow
    function automatic logic src_level(input logic [3:0] src, input logic fst,
                                       input logic slw, input logic ext,
                                       input logic [`IOS_DIV_W-1:0] div);
        logic [2:0] tap;
        tap = 3'h6 - src[2:0];
        if (src[3]) begin
            src_level = ext;
        end else if (src[2:0] == `IOS_SEL_FAST_FULL) begin
            src_level = fst;
        end else if (src[2:0] == `IOS_SEL_SLOW) begin
            src_level = slw;
        end else begin
            src_level = div[tap];
        end
    endfunction : src_level

    // readiness of the oscillator behind a source code
    function automatic logic src_ready(input logic [3:0] src, input logic frdy,
                                       input logic srdy);
        if (src[3]) begin
            src_ready = 1'b1;
        end else if (src[2:0] == `IOS_SEL_SLOW) begin
            src_ready = srdy;
        end else begin
            src_ready = frdy;
        end
    endfunction : src_ready

    logic cur_lvl;
    logic tgt_lvl;
    logic cur_lvl_q;
    logic tgt_lvl_q;
    logic same_osc;

    assign cur_lvl = src_level(cur_src, fast_lvl, slow_lvl, pin_a_lvl, post_div);
    assign tgt_lvl = src_level(tgt_src, fast_lvl, slow_lvl, pin_a_lvl, post_div);

    // both ends already on the fast postscaler: nothing to start
    assign same_osc = !des_src[3] && !cur_src[3] &&
                      (des_src[2:0] != `IOS_SEL_SLOW) && (cur_src[2:0] != `IOS_SEL_SLOW);

    // edge history of current and target sources
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cur_lvl_q <= 1'b0;
            tgt_lvl_q <= 1'b0;
        end else begin
            cur_lvl_q <= cur_lvl;
            tgt_lvl_q <= tgt_lvl;
        end
    end

    // ------------
    // glitch-free switch sequencer
    // ------------
    // a stalled current clock never gives its falling edge, so a switch away from
    // a dead source waits; software must keep the current source running
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sw_state <= ios_pkg::IOS_SW_IDLE;
            cur_src  <= {1'b0, `IOS_SEL_RESET};
            tgt_src  <= {1'b0, `IOS_SEL_RESET};
        end else begin
            unique case (sw_state)
                ios_pkg::IOS_SW_IDLE: begin
                    if (des_src != cur_src) begin
                        tgt_src <= des_src;
                        if (same_osc || src_ready(des_src, fast_rdy, slow_rdy)) begin
                            sw_state <= ios_pkg::IOS_SW_WAIT_FALL;
                        end else begin
                            sw_state <= ios_pkg::IOS_SW_START;
                        end
                    end
                end
                ios_pkg::IOS_SW_START: begin
                    if (src_ready(tgt_src, fast_rdy, slow_rdy)) begin
                        sw_state <= ios_pkg::IOS_SW_WAIT_FALL;
                    end
                end
                ios_pkg::IOS_SW_WAIT_FALL: begin
                    if (cur_lvl_q && !cur_lvl) begin
                        sw_state <= ios_pkg::IOS_SW_HOLD_LOW;
                    end
                end
                ios_pkg::IOS_SW_HOLD_LOW: begin
                    if (!tgt_lvl_q && tgt_lvl) begin
                        cur_src  <= tgt_src;
                        sw_state <= ios_pkg::IOS_SW_IDLE;
                    end
                end
            endcase
        end
    end

    // system clock: follows current source, forced low during the hand-over
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sys_clk_out <= 1'b0;
        end else if (sw_state == ios_pkg::IOS_SW_HOLD_LOW) begin
            sys_clk_out <= (!tgt_lvl_q && tgt_lvl);
        end else begin
            sys_clk_out <= cur_lvl;
        end
    end

    // ------------
    // oscillator enables and stable status
    // ------------
    logic cur_fast;
    logic cur_slow;
    logic tgt_fast;
    logic tgt_slow;
    logic switching;

    assign switching = (sw_state != ios_pkg::IOS_SW_IDLE);
    assign cur_fast  = !cur_src[3] && (cur_src[2:0] != `IOS_SEL_SLOW);
    assign cur_slow  = !cur_src[3] && (cur_src[2:0] == `IOS_SEL_SLOW);
    assign tgt_fast  = switching && !tgt_src[3] && (tgt_src[2:0] != `IOS_SEL_SLOW);
    assign tgt_slow  = switching && !tgt_src[3] && (tgt_src[2:0] == `IOS_SEL_SLOW);

    // running and target oscillators stay on until the switch is done
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fast_osc_enable <= 1'b0;
            slow_osc_enable <= 1'b0;
        end else begin
            fast_osc_enable <= ((freq_sel != `IOS_SEL_SLOW) &&
                                (sys_clk_sel || two_speed_enable || internal_mode)) ||
                               cur_fast || tgt_fast;
            slow_osc_enable <= ((freq_sel == `IOS_SEL_SLOW) &&
                                (sys_clk_sel || two_speed_enable || internal_mode)) ||
                               power_up_delay_timer_en || watchdog_counter_en ||
                               clock_fail_monitor_en || cur_slow || tgt_slow;
        end
    end

    // stable bits show an enabled and ready oscillator, refreshed every cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fast_stable <= 1'b0;
            slow_stable <= 1'b0;
        end else begin
            fast_stable <= fast_rdy && fast_osc_enable;
            slow_stable <= slow_rdy && slow_osc_enable;
        end
    end

    // ------------
    // gradual trim toward the written target
    // ------------
    logic [15:0] trim_tick;
    logic        trim_step;

    assign trim_step = (trim_tick == 16'(TRIM_STEP_CYC - 1));

    // step timer, free running; it has no completion flag by design
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trim_tick <= '0;
        end else if (trim_step) begin
            trim_tick <= '0;
        end else begin
            trim_tick <= trim_tick + 16'h0001;
        end
    end

    // one code per step, compared as signed so 10000 is lowest, 01111 highest
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trim_value <= `IOS_TRIM_RESET;
        end else if (trim_step) begin
            if ($signed(trim_value) < $signed(trim_target)) begin
                trim_value <= trim_value + 5'h01;
            end else if ($signed(trim_value) > $signed(trim_target)) begin
                trim_value <= trim_value - 5'h01;
            end
        end
    end

    // ------------
    // divided clock out and pin functions
    // ------------
    logic [1:0] clk_div4;
    logic       sys_clk_q;
    logic       divided_clock_out;
    logic       rc_mode;
    logic       rc_io_mode;
    logic       int_clko_mode;
    logic       int_io_mode;
    logic       ec_mode;

    // count rising edges of the system clock; bit 1 is the quarter rate
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sys_clk_q <= 1'b0;
            clk_div4  <= 2'h0;
        end else begin
            sys_clk_q <= sys_clk_out;
            if (sys_clk_out && !sys_clk_q) begin
                clk_div4 <= clk_div4 + 2'h1;
            end
        end
    end

    assign divided_clock_out = clk_div4[1];
    assign rc_mode       = (osc_mode_config == ios_pkg::IOS_MODE_RC);
    assign rc_io_mode    = (osc_mode_config == ios_pkg::IOS_MODE_RC_WITH_IO);
    assign int_clko_mode = (osc_mode_config == ios_pkg::IOS_MODE_INTERNAL_WITH_CLKO);
    assign int_io_mode   = (osc_mode_config == ios_pkg::IOS_MODE_INTERNAL_WITH_IO);
    assign ec_mode       = (osc_mode_config == ios_pkg::IOS_MODE_EC);

    // first pin: clock input except in the internal modes
    always_comb begin
        if (int_clko_mode || int_io_mode) begin
            osc_pin_in_o  = gpio_a_out;
            osc_pin_in_oe = gpio_a_oe;
        end else begin
            osc_pin_in_o  = 1'b0;
            osc_pin_in_oe = 1'b0;
        end
    end

    // second pin: quarter-rate clock, io, or crystal side
    always_comb begin
        if (rc_mode || int_clko_mode) begin
            osc_pin_out_o  = divided_clock_out;
            osc_pin_out_oe = 1'b1;
        end else if (rc_io_mode || int_io_mode || ec_mode) begin
            osc_pin_out_o  = gpio_b_out;
            osc_pin_out_oe = gpio_b_oe;
        end else begin
            osc_pin_out_o  = 1'b0;
            osc_pin_out_oe = 1'b0;
        end
    end

    // ------------
    // read port, data one cycle after the strobe
    // ------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `IOS_ADDR_OSC_CONTROL: reg_rdata <= {1'b0, freq_sel, cur_src[3],
                                                     fast_stable, slow_stable, sys_clk_sel};
                `IOS_ADDR_OSC_TRIM:    reg_rdata <= {3'h0, trim_target};
                default:               reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : ios_osc_select

`default_nettype wire

// *** verification/ios_osc_select_checker.sv ***
// checker: pin modes, read port, trim steps, slow enable
// assumes it is bound to ios_osc_select and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module ios_chk (
    // clock, reset and register port
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // configuration and pins
    input wire logic [2:0] osc_mode_config,
    input wire logic       watchdog_counter_en,
    input wire logic       gpio_a_oe,
    input wire logic       gpio_b_oe,
    input wire logic       osc_pin_in_oe,
    input wire logic       osc_pin_out_oe,
    // oscillator side
    input wire logic       slow_osc_enable,
    input wire logic [4:0] trim_value
);
    // ------------
    // properties
    // ------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // one trim step, then a quiet cycle: stepping is gradual
    sequence s_trim_move;
        $changed(trim_value) ##1 $stable(trim_value);
    endsequence
    a_rc_out_drive: assert property (osc_mode_config == 3'h7 |-> osc_pin_out_oe)
        else $error("rc mode leaves second pin undriven");
    a_rc_with_io_mode_pin_free: assert property (osc_mode_config == 3'h6 |-> osc_pin_out_oe == gpio_b_oe)
        else $error("rc io mode does not free second pin");
    a_clko_pins_set: assert property (osc_mode_config == 3'h5 |-> osc_pin_out_oe && osc_pin_in_oe == gpio_a_oe)
        else $error("internal divided_clock_out mode pins wrong");
    a_intio_pins_free: assert property (osc_mode_config == 3'h4 |->
        {osc_pin_in_oe, osc_pin_out_oe} == {gpio_a_oe, gpio_b_oe})
        else $error("internal io mode pins not free");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    a_trim_reset_zero: assert property ($rose(rstn) |-> trim_value == 5'h00)
        else $error("trim not zero after reset");
    a_trim_one_step: assert property ($changed(trim_value) |-> trim_value == $past(trim_value) + 5'h01
        || trim_value == $past(trim_value) - 5'h01)
        else $error("trim jumped more than one step");
    a_trim_step_gap: assert property ($changed(trim_value) |-> s_trim_move)
        else $error("trim stepped on consecutive cycles");
    a_timer_slow_on: assert property (watchdog_counter_en |=> slow_osc_enable)
        else $error("slow oscillator off while timer enabled");
endmodule : ios_chk

bind ios_osc_select ios_chk i_chk (.core_clk, .rstn, .reg_rd, .reg_rdata, .osc_mode_config, .watchdog_counter_en,
    .gpio_a_oe, .gpio_b_oe, .osc_pin_in_oe, .osc_pin_out_oe, .slow_osc_enable, .trim_value);

`default_nettype wire

// *** verification/ios_osc_select_test.sv ***
// self-checking bench over the register port and pins
// assumes the checker is compiled beside it; oscillators made from core_clk
`timescale 1ns/10ps
`default_nettype none

module ios_osc_select_test;
    // ------------
    // signals
    // ------------
    logic       core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, two_speed_enable = 1'b0;
    logic       power_up_delay_timer_en = 1'b0, watchdog_counter_en = 1'b0, clock_fail_monitor_en = 1'b0;
    logic       fast_internal_osc = 1'b0, slow_internal_osc = 1'b0, fast_osc_ready = 1'b1, slow_osc_ready = 1'b1;
    logic       osc_pin_in_i = 1'b0, osc_pin_out_i = 1'b0, gpio_a_out = 1'b0, gpio_b_out = 1'b0;
    logic       gpio_a_oe = 1'b0, gpio_b_oe = 1'b0, exp_oe;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val, cyc = 8'h00;
    logic [2:0] osc_mode_config = 3'h4;
    logic [4:0] trim_value;
    logic       fast_osc_enable, slow_osc_enable, sys_clk_out, slow_timebase_tick, osc_pin_in_o, osc_pin_in_oe;
    logic       osc_pin_out_o, osc_pin_out_oe, gpio_a_in, gpio_b_in;
    int         mismatches = 0, comparisons = 0, edges = 0, div_edges = 0, slow_n, i, ticks;

    ios_osc_select #(.TRIM_STEP_CYC(2)) i_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .osc_mode_config, .two_speed_enable, .power_up_delay_timer_en, .watchdog_counter_en,
        .clock_fail_monitor_en, .fast_internal_osc, .slow_internal_osc, .fast_osc_ready, .slow_osc_ready,
        .fast_osc_enable, .slow_osc_enable, .trim_value, .sys_clk_out, .slow_timebase_tick, .osc_pin_in_i,
        .osc_pin_in_o, .osc_pin_in_oe, .osc_pin_out_i, .osc_pin_out_o, .osc_pin_out_oe, .gpio_a_out, .gpio_a_oe,
        .gpio_b_out, .gpio_b_oe, .gpio_a_in, .gpio_b_in);

    // 50 ns clock; fast cell toggles each cycle, slow every 8, external every 2
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 8'h01;
        fast_internal_osc <= ~fast_internal_osc;
        slow_internal_osc <= cyc[3];
        osc_pin_in_i <= cyc[1];
    end
    // edge counters: system clock, divided output, slow timebase
    always @(posedge sys_clk_out) edges++;
    always @(posedge osc_pin_out_o) div_edges++;
    always @(negedge core_clk) ticks += slow_timebase_tick;

    // ------------
    // tasks
    // ------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe: sample mid-cycle
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rd_val = reg_rdata;
    endtask : rd
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // watchdog: tests take about five hundred cycles
    initial begin
        #(20000 * 50);
        mismatches++;
        final_report();
    end

    // ------------
    // tests
    // ------------
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(4'h0);
        chk(rd_val & 8'hf1, 8'h60);
        rd(4'h1);
        chk(rd_val, 8'h00);
        $display("test reset done");
        wr(4'h1, 8'h0f);
        rd(4'h1);
        chk(rd_val, 8'h0f);
        chk({7'h0, trim_value == 5'h0f}, 8'h00);
        repeat (40) @(posedge core_clk);
        chk({3'h0, trim_value}, 8'h0f);
        wr(4'h1, 8'hf0);
        rd(4'h1);
        chk(rd_val, 8'h10);
        repeat (80) @(posedge core_clk);
        chk({3'h0, trim_value}, 8'h10);
        wr(4'h2, 8'hff);
        rd(4'h2);
        chk(rd_val, 8'h00);
        $display("test trim done");
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            osc_mode_config <= i[2:0];
            {gpio_a_oe, gpio_a_out} <= {2{i[3]}};
            {gpio_b_oe, gpio_b_out, osc_pin_out_i} <= {3{i[3]}};
            @(negedge core_clk);
            exp_oe = (i[2:0] == 3'h5 || i[2:0] == 3'h7) ? 1'b1 : (i[2:0] inside {3'h3, 3'h4, 3'h6}) ? i[3] : 1'b0;
            chk({7'h0, osc_pin_out_oe}, {7'h0, exp_oe});
            if (i[2:1] == 2'b10) chk({6'h0, osc_pin_in_oe, osc_pin_in_o}, {6'h0, i[3], i[3]});
        end
        chk({7'h0, gpio_b_in}, 8'h01);
        $display("test pins done");
        @(posedge core_clk) osc_mode_config <= 3'h3;
        repeat (40) @(posedge core_clk);
        rd(4'h0);
        chk(rd_val & 8'h09, 8'h08);
        wr(4'h0, 8'h01);
        osc_mode_config <= 3'h5;
        repeat (60) @(posedge core_clk);
        rd(4'h0);
        chk(rd_val & 8'hfb, 8'h03);
        chk({7'h0, slow_osc_enable}, 8'h01);
        edges = 0;
        repeat (64) @(posedge core_clk);
        slow_n = edges;
        ticks = 0;
        wr(4'h0, 8'h71);
        repeat (60) @(posedge core_clk);
        rd(4'h0);
        chk(rd_val & 8'hfd, 8'h75);
        chk({7'h0, fast_osc_enable}, 8'h01);
        edges = 0;
        div_edges = 0;
        repeat (64) @(posedge core_clk);
        chk({7'h0, edges > 2 * slow_n}, 8'h01);
        chk({7'h0, div_edges * 4 <= edges + 4 && div_edges * 4 + 4 >= edges}, 8'h01);
        chk(8'(ticks), 8'h08);
        $display("test switch done");
        osc_mode_config <= 3'h3;
        wr(4'h0, 8'h70);
        repeat (40) @(posedge core_clk);
        chk({6'h0, fast_osc_enable, slow_osc_enable}, 8'h00);
        two_speed_enable <= 1'b1;
        watchdog_counter_en <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk({6'h0, fast_osc_enable, slow_osc_enable}, 8'h03);
        $display("test enables done");
        final_report();
    end
endmodule : ios_osc_select_test

`default_nettype wire
